// ### hdl/tdm_pkg.sv
// constants and types for the temporal direct motion scaler
`default_nettype none
package tdm_pkg;
	localparam int MV_W       = 16;
	localparam int DIST_W     = 9;
	localparam int SCALE_W    = 20;
	localparam int PROD_W     = 37;
	localparam int REF_W      = 5;
	localparam int PART_W     = 3;
	localparam int IDX_W      = 2;
	localparam logic signed [SCALE_W-1:0] SCALE_ONE = 20'sh00100;
	localparam logic signed [PROD_W-1:0]  ROUND_OFS = 37'sh0000000080;
	localparam int SHIFT      = 8;
	localparam int DIV_STEPS  = SCALE_W;
	typedef enum logic [1:0] {
		TDM_FRM_FRM,
		TDM_FLD_FLD,
		TDM_FLD_FRM,
		TDM_FRM_FLD
	} tdm_case_t;
endpackage
`default_nettype wire

// ### hdl/tdm_scaler.sv
// temporal direct motion vector scaler, one block per request
`default_nettype none
module tdm_scaler
(
	// clock and reset
	input  wire logic                         i_sys_clk,
	input  wire logic                         i_rst_n,
	// request from parser
	input  wire logic                         i_req_valid,
	output logic                              o_req_ready,
	input  wire logic                         i_direct_derivation_select,
	input  wire logic                         i_pair_adaptive_coding_enable,
	input  wire logic                         i_cur_field,
	input  wire logic                         i_col_field,
	input  wire logic                         i_second_field,
	input  wire logic                         i_col_ref_own_field0,
	input  wire logic                         i_col_intra,
	input  wire logic                         i_col_long_term,
	input  wire logic [tdm_pkg::PART_W-1:0]   i_col_partition,
	input  wire logic [tdm_pkg::REF_W-1:0]    i_col_ref_l0,
	input  wire logic [tdm_pkg::REF_W-1:0]    i_recent_ref_l0,
	input  wire logic signed [tdm_pkg::MV_W-1:0] i_col_mv_x,
	input  wire logic signed [tdm_pkg::MV_W-1:0] i_col_mv_y,
	input  wire logic signed [tdm_pkg::DIST_W-1:0] i_current_to_list0_distance,
	input  wire logic signed [tdm_pkg::DIST_W-1:0] i_list1_to_list0_distance,
	input  wire logic [tdm_pkg::IDX_W-1:0]    i_blk_x,
	input  wire logic [tdm_pkg::IDX_W-1:0]    i_blk_y,
	// result to prediction
	output logic                              o_res_valid,
	input  wire logic                         i_res_ready,
	output logic                              o_spatial,
	output logic [tdm_pkg::PART_W-1:0]        o_partition,
	output logic [tdm_pkg::REF_W-1:0]         o_ref_l0,
	output logic                              o_ref_l1_field0,
	output logic                              o_ref_same_parity,
	output logic                              o_field_mode,
	output logic [tdm_pkg::IDX_W-1:0]         o_col_blk_x,
	output logic [tdm_pkg::IDX_W:0]           o_col_blk_y,
	output logic signed [tdm_pkg::MV_W-1:0]   o_forward_vector_x,
	output logic signed [tdm_pkg::MV_W-1:0]   o_forward_vector_y,
	output logic signed [tdm_pkg::MV_W-1:0]   o_backward_vector_x,
	output logic signed [tdm_pkg::MV_W-1:0]   o_backward_vector_y
);

	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	function automatic logic signed [tdm_pkg::MV_W-1:0] scale_mv
	(
		input logic signed [tdm_pkg::SCALE_W-1:0] f,
		input logic signed [tdm_pkg::MV_W-1:0]    mv
	);
		logic signed [tdm_pkg::PROD_W-1:0] p;
		p = tdm_pkg::PROD_W'(f) * tdm_pkg::PROD_W'(mv) + tdm_pkg::ROUND_OFS;
		scale_mv = tdm_pkg::MV_W'(p >>> tdm_pkg::SHIFT);
	endfunction

	// magnitude of a signed distance, full range kept unsigned
	function automatic logic [tdm_pkg::DIST_W-1:0] abs_dist
	(
		input logic signed [tdm_pkg::DIST_W-1:0] d
	);
		abs_dist = d[tdm_pkg::DIST_W-1] ? tdm_pkg::DIST_W'(-d) : tdm_pkg::DIST_W'(d);
	endfunction

	// frame/field combination of current and co-located macroblock
	function automatic tdm_pkg::tdm_case_t decode_case
	(
		input logic cur,
		input logic col
	);
		case ({cur, col})
			2'b11:   decode_case = tdm_pkg::TDM_FLD_FLD;
			2'b10:   decode_case = tdm_pkg::TDM_FLD_FRM;
			2'b01:   decode_case = tdm_pkg::TDM_FRM_FLD;
			default: decode_case = tdm_pkg::TDM_FRM_FRM;
		endcase
	endfunction

	// requests answered without the divider
	function automatic logic fast_path
	(
		input logic sel,
		input logic intra,
		input logic lt
	);
		fast_path = sel || intra || lt;
	endfunction

	typedef enum logic [1:0] {
		TDM_IDLE,
		TDM_DIV,
		TDM_SCALE,
		TDM_OUT
	} tdm_state_t;

	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	tdm_state_t                              state_r;
	tdm_pkg::tdm_case_t                      case_r;
	logic                                    neg_r;
	logic                                    lt_r;
	logic                                    intra_r;
	logic                                    spat_r;
	logic signed [tdm_pkg::MV_W-1:0]         mvx_r;
	logic signed [tdm_pkg::MV_W-1:0]         mvy_r;
	logic [tdm_pkg::SCALE_W-1:0]             num_r;
	logic [tdm_pkg::DIST_W-1:0]              den_r;
	logic [tdm_pkg::SCALE_W-1:0]             quo_r;
	logic [tdm_pkg::DIST_W:0]                rem_r;
	logic [4:0]                              cnt_r;
	logic [tdm_pkg::DIST_W:0]                rem_nxt;
	logic                                    take;

	assign o_req_ready = (state_r == TDM_IDLE);
	assign o_res_valid = (state_r == TDM_OUT);
	assign take        = i_req_valid && o_req_ready;
	assign rem_nxt     = {rem_r[tdm_pkg::DIST_W-1:0], num_r[tdm_pkg::SCALE_W-1]};

	// ---------------------------------------------------------------
	// sequencing
	// ---------------------------------------------------------------
	always_ff @(posedge i_sys_clk)
	begin
		if (!i_rst_n)
			state_r <= TDM_IDLE;
		else
		begin
			case (state_r)
				TDM_IDLE:
					if (take)
						state_r <= fast_path(i_direct_derivation_select, i_col_intra, i_col_long_term)
							? TDM_OUT : TDM_DIV;
				TDM_DIV:
					if (cnt_r == 5'h01)
						state_r <= TDM_SCALE;
				TDM_SCALE:
					state_r <= TDM_OUT;
				TDM_OUT:
					if (i_res_ready)
						state_r <= TDM_IDLE;
				default:
					state_r <= TDM_IDLE;
			endcase
		end
	end

	// ---------------------------------------------------------------
	// capture of request
	// ---------------------------------------------------------------
	always_ff @(posedge i_sys_clk)
	begin
		if (!i_rst_n)
		begin
			case_r  <= tdm_pkg::TDM_FRM_FRM;
			neg_r   <= 1'b0;
			lt_r    <= 1'b0;
			intra_r <= 1'b0;
			spat_r  <= 1'b0;
			mvx_r   <= 16'sh0000;
			mvy_r   <= 16'sh0000;
		end
		else if (take)
		begin
			case_r  <= decode_case(i_cur_field, i_col_field);
			// second field to own field 0 flips the current distance, in the field/field case only
			neg_r   <= i_second_field && i_col_ref_own_field0;
			lt_r    <= i_col_long_term;
			intra_r <= i_col_intra;
			spat_r  <= i_direct_derivation_select;
			mvx_r   <= i_col_mv_x;
			mvy_r   <= i_col_mv_y;
		end
	end

	// ---------------------------------------------------------------
	// unsigned restoring divide of |tdb|*256 by |tdd|
	// ---------------------------------------------------------------
	always_ff @(posedge i_sys_clk)
	begin
		if (!i_rst_n)
		begin
			num_r <= 20'h00000;
			den_r <= 9'h000;
			quo_r <= 20'h00000;
			rem_r <= 10'h000;
			cnt_r <= 5'h00;
		end
		else if (take)
		begin
			num_r <= tdm_pkg::SCALE_W'(abs_dist(i_current_to_list0_distance)) << tdm_pkg::SHIFT;
			den_r <= abs_dist(i_list1_to_list0_distance);
			quo_r <= 20'h00000;
			rem_r <= 10'h000;
			cnt_r <= 5'(tdm_pkg::DIV_STEPS);
		end
		else if (state_r == TDM_DIV)
		begin
			num_r <= {num_r[tdm_pkg::SCALE_W-2:0], 1'b0};
			cnt_r <= cnt_r - 5'h01;
			if (den_r != 9'h000 && rem_nxt >= {1'b0, den_r})
			begin
				rem_r <= rem_nxt - {1'b0, den_r};
				quo_r <= {quo_r[tdm_pkg::SCALE_W-2:0], 1'b1};
			end
			else
			begin
				rem_r <= rem_nxt;
				quo_r <= {quo_r[tdm_pkg::SCALE_W-2:0], 1'b0};
			end
		end
	end

	// sign of scale: tdb sign xor tdd sign, xor negation in the field/field case only
	logic sgn_r;
	always_ff @(posedge i_sys_clk)
	begin
		if (!i_rst_n)
			sgn_r <= 1'b0;
		else if (take)
			sgn_r <= i_current_to_list0_distance[tdm_pkg::DIST_W-1] ^ i_list1_to_list0_distance[tdm_pkg::DIST_W-1];
	end

	logic signed [tdm_pkg::SCALE_W-1:0] z_s;
	logic signed [tdm_pkg::SCALE_W-1:0] w_s;
	assign z_s = (sgn_r ^ (neg_r && case_r == tdm_pkg::TDM_FLD_FLD)) ? -$signed(quo_r) : $signed(quo_r);
	assign w_s = z_s - tdm_pkg::SCALE_ONE;

	// ---------------------------------------------------------------
	// forward vector
	// ---------------------------------------------------------------
	always_ff @(posedge i_sys_clk)
	begin
		if (!i_rst_n)
		begin
			o_forward_vector_x  <= 16'sh0000;
			o_forward_vector_y  <= 16'sh0000;
		end
		else if (take)
		begin
			if (i_col_intra || i_direct_derivation_select)
			begin
				o_forward_vector_x  <= 16'sh0000;
				o_forward_vector_y  <= 16'sh0000;
			end
			else if (i_col_long_term)
			begin
				o_forward_vector_x  <= i_col_mv_x;
				o_forward_vector_y  <= i_col_mv_y;
			end
		end
		else if (state_r == TDM_SCALE && !spat_r && !intra_r && !lt_r)
		begin
			o_forward_vector_x  <= scale_mv(z_s, mvx_r);
			o_forward_vector_y  <= scale_mv(z_s, mvy_r);
		end
	end

	// ---------------------------------------------------------------
	// backward vector
	// ---------------------------------------------------------------
	always_ff @(posedge i_sys_clk)
	begin
		if (!i_rst_n)
		begin
			o_backward_vector_x <= 16'sh0000;
			o_backward_vector_y <= 16'sh0000;
		end
		else if (take)
		begin
			if (fast_path(i_direct_derivation_select, i_col_intra, i_col_long_term))
			begin
				o_backward_vector_x <= 16'sh0000;
				o_backward_vector_y <= 16'sh0000;
			end
		end
		else if (state_r == TDM_SCALE && !spat_r && !intra_r && !lt_r)
		begin
			o_backward_vector_x <= scale_mv(w_s, mvx_r);
			o_backward_vector_y <= scale_mv(w_s, mvy_r);
		end
	end

	// ---------------------------------------------------------------
	// references, partition, spatial flag and field mode
	// ---------------------------------------------------------------
	always_ff @(posedge i_sys_clk)
	begin
		if (!i_rst_n)
		begin
			o_spatial         <= 1'b0;
			o_partition       <= 3'h0;
			o_ref_l0          <= 5'h00;
			o_ref_l1_field0   <= 1'b0;
			o_ref_same_parity <= 1'b0;
			o_field_mode      <= 1'b0;
		end
		else if (take)
		begin
			o_spatial    <= i_direct_derivation_select;
			o_partition  <= i_col_partition;
			o_ref_l0     <= i_col_intra ? i_recent_ref_l0 : i_col_ref_l0;
			// frame over field and first field over field take list 1 field 0
			o_ref_l1_field0   <= (i_cur_field && i_col_field && !i_second_field)
				|| (!i_cur_field && i_col_field);
			o_ref_same_parity <= i_cur_field && !i_col_field;
			o_field_mode <= i_pair_adaptive_coding_enable ? i_col_field : i_cur_field;
		end
	end

	// ---------------------------------------------------------------
	// co-located block position
	// ---------------------------------------------------------------
	always_ff @(posedge i_sys_clk)
	begin
		if (!i_rst_n)
		begin
			o_col_blk_x <= 2'h0;
			o_col_blk_y <= 3'h0;
		end
		else if (take)
		begin
			o_col_blk_x <= i_blk_x;
			case (decode_case(i_cur_field, i_col_field))
				tdm_pkg::TDM_FLD_FRM: o_col_blk_y <= {i_blk_y, 1'b0};
				tdm_pkg::TDM_FRM_FLD: o_col_blk_y <= {2'b00, i_blk_y[1]};
				default:              o_col_blk_y <= {1'b0, i_blk_y};
			endcase
		end
	end

endmodule
`default_nettype wire

// ### verification/tdm_scaler_props.sv
// assertion checker for the temporal direct scaler
`default_nettype none
module tdm_scaler_chk
(
	// watched ports
	input wire logic                    i_sys_clk,
	input wire logic                    i_rst_n,
	input wire logic                    i_req_valid,
	input wire logic                    o_req_ready,
	input wire logic                    i_res_ready,
	input wire logic                    o_res_valid,
	input wire logic                    i_direct_derivation_select,
	input wire logic                    i_col_intra,
	input wire logic                    i_col_long_term,
	input wire logic [2:0]              i_col_partition,
	input wire logic [4:0]              i_col_ref_l0,
	input wire logic [4:0]              i_recent_ref_l0,
	input wire logic signed [15:0]      i_col_mv_x,
	input wire logic                    o_spatial,
	input wire logic [2:0]              o_partition,
	input wire logic [4:0]              o_ref_l0,
	input wire logic signed [15:0]      o_forward_vector_x,
	input wire logic signed [15:0]      o_backward_vector_x
);
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (!i_rst_n);
	wire logic tk = i_req_valid && o_req_ready;
	wire logic tmp = tk && !i_direct_derivation_select;
	property p_hold; o_res_valid && !i_res_ready |=> o_res_valid && $stable(o_forward_vector_x)
		&& $stable(o_ref_l0); endproperty
	a_hold: assert property (p_hold) else $error("result changed while stalled");
	property p_busy; o_res_valid |-> !o_req_ready; endproperty
	a_busy: assert property (p_busy) else $error("ready while result pending");
	property p_next; o_res_valid && i_res_ready |=> o_req_ready && !o_res_valid; endproperty
	a_next: assert property (p_next) else $error("not idle after accept");
	property p_spat; tk && i_direct_derivation_select |=> o_res_valid && o_spatial
		&& o_forward_vector_x == 16'h0000 && o_backward_vector_x == 16'h0000; endproperty
	a_spat: assert property (p_spat) else $error("spatial result wrong");
	property p_intra; tmp && i_col_intra |=> o_res_valid && !o_spatial && o_forward_vector_x == 16'h0000
		&& o_ref_l0 == $past(i_recent_ref_l0); endproperty
	a_intra: assert property (p_intra) else $error("intra result wrong");
	property p_lt; tmp && !i_col_intra && i_col_long_term |=> o_forward_vector_x == $past(i_col_mv_x)
		&& o_backward_vector_x == 16'h0000; endproperty
	a_lt: assert property (p_lt) else $error("long-term vectors wrong");
	property p_ref; tmp && !i_col_intra && i_col_long_term |=> o_ref_l0 == $past(i_col_ref_l0)
		&& o_partition == $past(i_col_partition); endproperty
	a_ref: assert property (p_ref) else $error("reference or partition wrong");
	property p_slow; tmp && !i_col_intra && !i_col_long_term |=> !o_res_valid [*8] ##13 !o_res_valid
		##1 o_res_valid; endproperty
	a_slow: assert property (p_slow) else $error("scaled result latency wrong");
	c_spat: cover property (tk && i_direct_derivation_select);
	c_slow: cover property (tmp && !i_col_intra && !i_col_long_term);
	c_stall: cover property (o_res_valid && !i_res_ready ##1 i_res_ready);
endmodule
bind tdm_scaler tdm_scaler_chk u_chk (.*);
`default_nettype wire

// ### verification/tdm_pred_sink.sv
// prediction stage model accepting results after a set stall
`default_nettype none
module tdm_pred_sink
(
	// clock and reset
	input  wire logic       i_sys_clk,
	input  wire logic       i_rst_n,
	// result handshake
	input  wire logic       i_res_valid,
	input  wire logic [3:0] i_stall,
	output logic            o_res_ready
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [3:0] wait_r;
	assign o_res_ready = i_res_valid && (wait_r >= i_stall);
	always_ff @(posedge i_sys_clk)
	begin
		if (!i_rst_n || !i_res_valid || o_res_ready)
			wait_r <= 4'h0;
		else
			wait_r <= wait_r + 4'h1;
	end
endmodule
`default_nettype wire

// ### verification/test_temporal_direct_mv_scaler.sv
// self-checking bench for the temporal direct scaler
`default_nettype none
module test_temporal_direct_mv_scaler;
	timeunit 1ns;
	timeprecision 1ns;
	logic i_sys_clk = 0, i_rst_n = 0, i_req_valid = 0, i_res_ready;
	logic i_direct_derivation_select = 0, i_pair_adaptive_coding_enable = 0, i_cur_field = 0;
	logic i_col_field = 0, i_second_field = 0, i_col_ref_own_field0 = 0, i_col_intra = 0, i_col_long_term = 0;
	logic [2:0] i_col_partition = 0, o_partition, o_col_blk_y;
	logic [4:0] i_col_ref_l0 = 0, i_recent_ref_l0 = 0, o_ref_l0;
	logic [1:0] i_blk_x = 0, i_blk_y = 0, o_col_blk_x;
	logic signed [15:0] i_col_mv_x = 0, i_col_mv_y = 0, o_forward_vector_x, o_forward_vector_y;
	logic signed [15:0] o_backward_vector_x, o_backward_vector_y;
	logic signed [8:0] i_current_to_list0_distance = 0, i_list1_to_list0_distance = 0;
	logic o_req_ready, o_res_valid, o_spatial, o_ref_l1_field0, o_ref_same_parity, o_field_mode;
	logic [3:0] stall = 0;
	int n_mismatch = 0, samples_checked = 0;
	tdm_scaler u_dut (.*);
	tdm_pred_sink u_sink (.i_sys_clk, .i_rst_n, .i_res_valid(o_res_valid), .i_stall(stall), .o_res_ready(i_res_ready));
	initial forever #50 i_sys_clk = ~i_sys_clk;
	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task automatic print_verdict;
		$display("mismatches %0d comparisons %0d", n_mismatch, samples_checked);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic chk(input logic [15:0] g, e);
		samples_checked++;
		if (g !== e)
			begin
			n_mismatch++;
			$display("ERROR %0t got %h want %h", $time, g, e);
		end
	endtask
	task automatic set(input logic [7:0] f, input logic [15:0] x, y, input logic [8:0] t, d);
		{i_direct_derivation_select, i_pair_adaptive_coding_enable, i_cur_field, i_col_field,
			i_second_field, i_col_ref_own_field0, i_col_intra, i_col_long_term} <= f;
		{i_col_mv_x, i_col_mv_y} <= {x, y};
		{i_current_to_list0_distance, i_list1_to_list0_distance} <= {t, d};
	endtask
	task automatic go;
		int k;
		k = 0;
		i_req_valid <= 1'b1;
		@(posedge i_sys_clk);
		i_req_valid <= 1'b0;
		@(negedge i_sys_clk);
		while (!(o_res_valid && i_res_ready) && k < 40)
		begin
			k++;
			@(negedge i_sys_clk);
		end
		if (k == 40)
		begin
			n_mismatch++;
			$display("ERROR %0t no result", $time);
		end
		@(posedge i_sys_clk);
	endtask
	task automatic sc(input int t, d, mx, my, input logic neg);
		int z;
		z = neg ? -((t * 256) / d) : (t * 256) / d;
		chk(o_forward_vector_x, 16'((z * mx + 128) >>> 8));
		chk(o_forward_vector_y, 16'((z * my + 128) >>> 8));
		chk(o_backward_vector_x, 16'(((z - 256) * mx + 128) >>> 8));
		chk(o_backward_vector_y, 16'(((z - 256) * my + 128) >>> 8));
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_spatial;
		set(8'h80, 16'h012C, 16'h0037, 9'h001, 9'h002);
		go();
		chk({15'h0000, o_spatial}, 16'h0001);
		chk(o_forward_vector_x | o_backward_vector_y, 16'h0000);
	endtask
	task automatic t_intra;
		stall <= 4'h3;
		i_recent_ref_l0 <= 5'h09;
		set(8'h03, 16'h004D, 16'h0037, 9'h001, 9'h002);
		go();
		chk(o_forward_vector_y | o_backward_vector_x, 16'h0000);
		chk({11'h000, o_ref_l0}, 16'h0009);
	endtask
	task automatic t_long;
		i_col_ref_l0 <= 5'h0C;
		i_col_partition <= 3'h5;
		set(8'h01, 16'hFB2E, 16'h0037, 9'h001, 9'h002);
		go();
		chk(o_forward_vector_x, 16'hFB2E);
		chk(o_forward_vector_y, 16'h0037);
		chk(o_backward_vector_x | o_backward_vector_y, 16'h0000);
		chk({11'h000, o_ref_l0}, 16'h000C);
		chk({13'h0000, o_partition}, 16'h0005);
	endtask
	task automatic t_frame;
		set(8'h00, 16'hFFDB, 16'h0064, 9'h001, 9'h003);
		go();
		sc(1, 3, -37, 100, 1'b0);
	endtask
	task automatic t_field;
		stall <= 4'h1;
		set(8'h7C, 16'h0201, 16'hFFF7, 9'h002, 9'h005);
		go();
		sc(2, 5, 513, -9, 1'b1);
		chk({15'h0000, o_field_mode}, 16'h0001);
		set(8'h78, 16'h0201, 16'hFFF7, 9'h002, 9'h005);
		go();
		sc(2, 5, 513, -9, 1'b0);
	endtask
	task automatic t_mixed;
		stall <= 4'h0;
		i_blk_y <= 2'h1;
		set(8'h20, 16'h0100, 16'hFF00, 9'h003, 9'h004);
		go();
		sc(3, 4, 256, -256, 1'b0);
		chk({13'h0000, o_col_blk_y}, 16'h0002);
		i_blk_y <= 2'h3;
		set(8'h50, 16'h0100, 16'hFF00, 9'h003, 9'h004);
		go();
		sc(3, 4, 256, -256, 1'b0);
		chk({13'h0000, o_col_blk_y}, 16'h0001);
		chk({15'h0000, o_field_mode}, 16'h0001);
	endtask
	initial
	begin
		repeat (2000) @(posedge i_sys_clk);
		n_mismatch++;
		print_verdict();
	end
	initial
	begin
		repeat (8) @(posedge i_sys_clk);
		chk({14'h0000, o_req_ready, o_res_valid}, 16'h0002);
		i_rst_n <= 1'b1;
		t_spatial();
		t_intra();
		t_long();
		t_frame();
		t_field();
		t_mixed();
		print_verdict();
	end
endmodule
`default_nettype wire
